/* tvi_core_model.sv */
// Behavioural processor core facing the interrupt logic
`timescale 1ns/100ps
`default_nettype none
module tvi_core_model (
	input wire logic       aclk,       // Clock
	input wire logic       aresetn,    // Reset, low
	input wire logic       irq_req,    // Request
	input wire logic [3:0] gap,        // Extra cycles per instruction
	input wire logic       ret_go,     // Routine returns
	output var logic       instr_done, // Instruction finished
	output var logic       call_ack,   // Vector call taken
	output var logic       return_from_interrupt_done   // Return finished
);
	logic [3:0] cnt_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q      <= 4'h0;
			instr_done <= 1'b0;
			call_ack   <= 1'b0;
			return_from_interrupt_done  <= 1'b0;
		end else begin
			// Calls only at an instruction boundary
			call_ack   <= instr_done && irq_req && !call_ack;
			return_from_interrupt_done  <= ret_go && !return_from_interrupt_done;
			instr_done <= (cnt_q == 4'h0);
			cnt_q      <= (cnt_q == 4'h0) ? gap : cnt_q - 4'h1;
		end
	end
endmodule // tvi_core_model
`default_nettype wire

/* tvi_irq_ctrl.sv */
// Two-level vectored interrupt logic with an AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "tvi_regs.svh"
module tvi_irq_ctrl (
	input  wire logic                        aclk,         // System clock
	input  wire logic                        aresetn,      // Synchronous reset, low
	input  wire logic [`TVI_ADDR_W-1:0]      awaddr,       // Write address
	input  wire logic [2:0]                  awprot,       // Write protection, unused
	input  wire logic                        awvalid,      // Write address valid
	output logic                             awready,      // Write address ready
	input  wire logic [31:0]                 wdata,        // Write data
	input  wire logic [3:0]                  wstrb,        // Write byte strobes
	input  wire logic                        wvalid,       // Write data valid
	output logic                             wready,       // Write data ready
	output logic [1:0]                       bresp,        // Write response
	output logic                             bvalid,       // Write response valid
	input  wire logic                        bready,       // Write response ready
	input  wire logic [`TVI_ADDR_W-1:0]      araddr,       // Read address
	input  wire logic [2:0]                  arprot,       // Read protection, unused
	input  wire logic                        arvalid,      // Read address valid
	output logic                             arready,      // Read address ready
	output logic [31:0]                      rdata,        // Read data
	output logic [1:0]                       rresp,        // Read response
	output logic                             rvalid,       // Read data valid
	input  wire logic                        rready,       // Read data ready
	input  wire logic [`TVI_SRC_CNT-1:0]     src_event,    // Source condition pulses
	input  wire logic                        instr_done,   // Core finished an instruction
	input  wire logic                        call_ack,     // Core starts the vector call
	input  wire logic                        return_from_interrupt_done,    // Core completed return
	output logic                             irq_req,      // Request to the core
	output logic [15:0]                      irq_vector,   // Vector address to call
	output logic                             irq_high,     // Request is high level
	output logic [`TVI_IDX_W-1:0]            irq_source    // Winning source position
);
	localparam int SRC = `TVI_SRC_CNT;

	localparam tvi_pkg::tvi_state_type RST = '{
		basic_irq_enable_reg:      `TVI_REG8_RESET,
		extended_irq_enable_reg_a: `TVI_REG8_RESET,
		extended_irq_enable_reg_b: `TVI_REG8_RESET,
		basic_priority_reg:        `TVI_REG8_RESET,
		extended_priority_reg_a:   `TVI_REG8_RESET,
		extended_priority_reg_b:   `TVI_REG8_RESET,
		awready:                   1'b1,
		wready:                    1'b1,
		arready:                   1'b1,
		default:                   '0
	};

	tvi_pkg::tvi_state_type s_q;
	tvi_pkg::tvi_state_type s_d;

	tvi_pick_if #(.N(SRC)) pick_bus ();

	tvi_pick #(
		.N (SRC)
	) u_pick (
		.p (pick_bus)
	);

	// Address decode, shared by the read and write paths
	function automatic tvi_pkg::tvi_sel_type reg_sel(input logic [`TVI_ADDR_W-1:0] a);
		unique case (a)
			`TVI_OFF_EN_BASIC: reg_sel = tvi_pkg::TVI_SEL_EN_BASIC;
			`TVI_OFF_EN_EXT_A: reg_sel = tvi_pkg::TVI_SEL_EN_EXT_A;
			`TVI_OFF_EN_EXT_B: reg_sel = tvi_pkg::TVI_SEL_EN_EXT_B;
			`TVI_OFF_PR_BASIC: reg_sel = tvi_pkg::TVI_SEL_PR_BASIC;
			`TVI_OFF_PR_EXT_A: reg_sel = tvi_pkg::TVI_SEL_PR_EXT_A;
			`TVI_OFF_PR_EXT_B: reg_sel = tvi_pkg::TVI_SEL_PR_EXT_B;
			`TVI_OFF_PEND_SET: reg_sel = tvi_pkg::TVI_SEL_PEND_SET;
			`TVI_OFF_PEND_CLR: reg_sel = tvi_pkg::TVI_SEL_PEND_CLR;
			`TVI_OFF_STATUS:   reg_sel = tvi_pkg::TVI_SEL_STATUS;
			default:           reg_sel = tvi_pkg::TVI_SEL_NONE;
		endcase
	endfunction

	// Gather per-source bits from the basic and the two extended registers
	function automatic logic [SRC-1:0] src_bits(
		input logic [7:0] basic,
		input logic [7:0] ext_a,
		input logic [7:0] ext_b
	);
		src_bits = {ext_b[`TVI_EXT_B_SRC_CNT-1:0], ext_a, basic[`TVI_BASIC_SRC_CNT-1:0]};
	endfunction

	// Byte strobes widened to one bit per pending flag
	function automatic logic [SRC-1:0] lane_mask(input logic [3:0] strb);
		lane_mask = '0;
		for (int i = 0; i < SRC; i++) begin
			lane_mask[i] = strb[i / 8];
		end
	endfunction

	function automatic logic [31:0] read_mux(
		input tvi_pkg::tvi_sel_type sel,
		input tvi_pkg::tvi_state_type s
	);
		read_mux = 32'h0000_0000;
		unique case (sel)
			tvi_pkg::TVI_SEL_EN_BASIC: read_mux[7:0] = s.basic_irq_enable_reg;
			tvi_pkg::TVI_SEL_EN_EXT_A: read_mux[7:0] = s.extended_irq_enable_reg_a;
			tvi_pkg::TVI_SEL_EN_EXT_B: read_mux[7:0] = s.extended_irq_enable_reg_b;
			tvi_pkg::TVI_SEL_PR_BASIC: read_mux[6:0] = s.basic_priority_reg[6:0];
			tvi_pkg::TVI_SEL_PR_EXT_A: read_mux[7:0] = s.extended_priority_reg_a;
			tvi_pkg::TVI_SEL_PR_EXT_B: read_mux[7:0] = s.extended_priority_reg_b;
			tvi_pkg::TVI_SEL_PEND_SET: read_mux[SRC-1:0] = s.pend;
			tvi_pkg::TVI_SEL_PEND_CLR: read_mux = 32'h0000_0000;
			tvi_pkg::TVI_SEL_STATUS:   read_mux = {
				16'h0000,
				3'h0, s.idx,
				3'h0, s.hold,
				s.high, s.req,
				s.active
			};
			tvi_pkg::TVI_SEL_NONE:     read_mux = 32'h0000_0000;
		endcase
	endfunction

	logic                 global_on;
	logic [SRC-1:0]       en_vec;
	logic [SRC-1:0]       pr_vec;
	logic [SRC-1:0]       live;
	logic [SRC-1:0]       live_high;
	logic [SRC-1:0]       live_low;
	logic                 any_high;
	logic                 eligible;
	logic [SRC-1:0]       sw_set;
	logic [SRC-1:0]       sw_clr;
	logic [SRC-1:0]       hw_clr;
	logic                 wr_fire;
	tvi_pkg::tvi_sel_type wr_sel;
	logic [SRC-1:0]       wr_lanes;

	always_comb begin
		s_d = s_q;

		global_on = s_q.basic_irq_enable_reg[`TVI_GLOBAL_EN_BIT];
		en_vec    = src_bits(s_q.basic_irq_enable_reg, s_q.extended_irq_enable_reg_a,
			s_q.extended_irq_enable_reg_b);
		pr_vec    = src_bits(s_q.basic_priority_reg, s_q.extended_priority_reg_a,
			s_q.extended_priority_reg_b);

		// Disabled or globally blocked flags never reach the encoder
		live      = s_q.pend & en_vec & {SRC{global_on}};
		live_high = live & pr_vec;
		live_low  = live & ~pr_vec;
		any_high  = |live_high;
		pick_bus.req = any_high ? live_high : live_low;

		// High may enter unless high already runs; low only when idle
		if (any_high) begin
			eligible = !s_q.active[1];
		end else begin
			eligible = (s_q.active == 2'b00);
		end

		// Registered request: one cycle of detect, refreshed every cycle.
		// A flag disabled in this cycle can still be seen by a core that
		// reaches its boundary next cycle; a longer instruction sees it gone.
		s_d.req  = pick_bus.found && eligible && !s_q.hold && !call_ack;
		s_d.high = any_high;
		s_d.idx  = pick_bus.idx;
		s_d.vec  = `TVI_VEC_BASE + (16'(pick_bus.idx) << `TVI_VEC_SHIFT);

		// Vector call taken by the core
		hw_clr = '0;
		if (call_ack && s_q.req) begin
			if (s_q.high) begin
				s_d.active[1] = 1'b1;
			end else begin
				s_d.active[0] = 1'b1;
			end
			hw_clr[s_q.idx] = 1'(`TVI_HW_CLR_MASK >> s_q.idx);
		end

		// One more instruction must finish after a return before re-entry
		if (instr_done) begin
			s_d.hold = 1'b0;
		end
		if (return_from_interrupt_done) begin
			s_d.hold = 1'b1;
			if (s_q.active[1]) begin
				s_d.active[1] = 1'b0;
			end else begin
				s_d.active[0] = 1'b0;
			end
		end

		// Write channel: address and data taken in either order
		if (awvalid && s_q.awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = awaddr;
			s_d.awready = 1'b0;
		end
		if (wvalid && s_q.wready) begin
			s_d.w_have = 1'b1;
			s_d.w_data = wdata;
			s_d.w_strb = wstrb;
			s_d.wready = 1'b0;
		end

		wr_fire  = s_q.aw_have && s_q.w_have && !s_q.bvalid;
		wr_sel   = reg_sel(s_q.aw_addr);
		wr_lanes = lane_mask(s_q.w_strb);
		sw_set   = '0;
		sw_clr   = '0;
		if (wr_fire) begin
			s_d.bvalid = 1'b1;
			s_d.bresp  = `TVI_RESP_OKAY;
			unique case (wr_sel)
				tvi_pkg::TVI_SEL_EN_BASIC: begin
					if (s_q.w_strb[0]) begin
						s_d.basic_irq_enable_reg = s_q.w_data[7:0];
					end
				end
				tvi_pkg::TVI_SEL_EN_EXT_A: begin
					if (s_q.w_strb[0]) begin
						s_d.extended_irq_enable_reg_a = s_q.w_data[7:0];
					end
				end
				tvi_pkg::TVI_SEL_EN_EXT_B: begin
					if (s_q.w_strb[0]) begin
						s_d.extended_irq_enable_reg_b = s_q.w_data[7:0];
					end
				end
				tvi_pkg::TVI_SEL_PR_BASIC: begin
					if (s_q.w_strb[0]) begin
						s_d.basic_priority_reg = {1'b0, s_q.w_data[6:0]};
					end
				end
				tvi_pkg::TVI_SEL_PR_EXT_A: begin
					if (s_q.w_strb[0]) begin
						s_d.extended_priority_reg_a = s_q.w_data[7:0];
					end
				end
				tvi_pkg::TVI_SEL_PR_EXT_B: begin
					if (s_q.w_strb[0]) begin
						s_d.extended_priority_reg_b = s_q.w_data[7:0];
					end
				end
				tvi_pkg::TVI_SEL_PEND_SET: begin
					sw_set = s_q.w_data[SRC-1:0] & wr_lanes;
				end
				tvi_pkg::TVI_SEL_PEND_CLR: begin
					sw_clr = s_q.w_data[SRC-1:0] & wr_lanes;
				end
				tvi_pkg::TVI_SEL_STATUS: begin
					s_d.bresp = `TVI_RESP_OKAY;
				end
				tvi_pkg::TVI_SEL_NONE: begin
					s_d.bresp = `TVI_RESP_SLVERR;
				end
			endcase
		end
		if (s_q.bvalid && bready) begin
			s_d.bvalid  = 1'b0;
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready  = 1'b1;
		end

		// Clears first, then sets, so an event in the clear cycle survives
		s_d.pend = (s_q.pend & ~sw_clr & ~hw_clr) | sw_set | src_event;

		// Read channel: one outstanding read, answered the cycle after it is taken
		if (arvalid && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid  = 1'b1;
			s_d.rdata   = read_mux(reg_sel(araddr), s_q);
			s_d.rresp   = (reg_sel(araddr) == tvi_pkg::TVI_SEL_NONE) ? `TVI_RESP_SLVERR : `TVI_RESP_OKAY;
		end
		if (s_q.rvalid && rready) begin
			s_d.rvalid  = 1'b0;
			s_d.arready = 1'b1;
		end
	end

	// Reset clears every request and priority before any source is seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign awready    = s_q.awready;
	assign wready     = s_q.wready;
	assign bvalid     = s_q.bvalid;
	assign bresp      = s_q.bresp;
	assign arready    = s_q.arready;
	assign rvalid     = s_q.rvalid;
	assign rdata      = s_q.rdata;
	assign rresp      = s_q.rresp;
	assign irq_req    = s_q.req;
	assign irq_vector = s_q.vec;
	assign irq_high   = s_q.high;
	assign irq_source = s_q.idx;

endmodule // tvi_irq_ctrl
`default_nettype wire

/* tvi_irq_ctrl_bench.sv */
// Self-checking bench for the interrupt logic
`timescale 1ns/100ps
`default_nettype none
`include "tvi_regs.svh"
module tvi_irq_ctrl_bench;
	localparam logic [1:0] okay = `TVI_RESP_OKAY;
	localparam logic [1:0] slverr = `TVI_RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic instr_done, call_ack, return_from_interrupt_done, irq_req, irq_high, ret_go;
	logic [7:0]              awaddr, araddr;
	logic [31:0]             wdata, rdata;
	logic [3:0]              wstrb, gap;
	logic [1:0]              bresp, rresp;
	logic [`TVI_SRC_CNT-1:0] src_event;
	logic [15:0]             irq_vector;
	logic [4:0]              irq_source;
	logic [33:0]             qr[$], qb[$], qv[$];
	int                      n_fail, n_checks, cyc, s, h;

	always #2.5 aclk = ~aclk;

	tvi_irq_ctrl tvi_irq_ctrl_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .src_event(src_event), .instr_done(instr_done),
		.call_ack(call_ack), .return_from_interrupt_done(return_from_interrupt_done), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_high(irq_high), .irq_source(irq_source));
	tvi_core_model tvi_core_model_i (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req), .gap(gap),
		.ret_go(ret_go), .instr_done(instr_done), .call_ack(call_ack), .return_from_interrupt_done(return_from_interrupt_done));

	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	function automatic logic [33:0] pop(ref logic [33:0] q[$]);
		return (q.size() != 0) ? q.pop_front() : 'x;
	endfunction

	function automatic logic [33:0] vec(input int i);
		return {18'h0, 16'h0003 + 16'(i * 8)};
	endfunction

	task chk(input string n, input logic [33:0] e, input logic [33:0] v);
		n_checks++;
		if (v !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, v);
		end
	endtask

	// Results are matched in arrival order; an unexpected call pops an empty queue
	always @(posedge aclk) begin
		cyc++;
		if (rvalid && rready) chk("read", pop(qr), {rresp, rdata});
		if (bvalid && bready) chk("write response", pop(qb), {32'h0, bresp});
		if (call_ack) chk("vector", pop(qv), {18'h0, irq_vector});
		if (cyc == 5000) begin
			n_fail++;
			finish_test;
		end
	end

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		qb.push_back({32'h0, r});
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		qr.push_back({r, d});
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask

	task ev(input logic [`TVI_SRC_CNT-1:0] m);
		@(posedge aclk);
		src_event <= m;
		@(posedge aclk);
		src_event <= '0;
	endtask

	task take;
		do @(posedge aclk); while (!call_ack);
	endtask

	task done(input int i, input bit c);
		if (c) wr(8'h1C, 32'h1 << i, okay);
		@(posedge aclk);
		ret_go <= 1'b1;
		@(posedge aclk);
		ret_go <= 1'b0;
	endtask

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, ret_go} = '0;
		{awaddr, araddr, wdata, src_event} = '0;
		wstrb = 4'hF;
		gap = 4'h2;
		aresetn = 1'b0;
		{n_fail, n_checks, cyc} = '0;
		void'($urandom(32'hC0F227D3));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0, okay);
		rd(8'h24, 32'h0, slverr);
		wr(8'h24, 32'hFF, slverr);
		s = 4 + $urandom % 3;
		h = 7 + $urandom % 8;
		gap <= 4'(1 + $urandom % 7);
		ev(17'h00001 << s);
		rd(8'h18, 32'h1 << s, okay);
		wr(8'h04, 32'hFF, okay);
		wr(8'h08, 32'h03, okay);
		rd(8'h04, 32'hFF, okay);
		wr(8'h00, 32'h7F, okay);
		repeat (20) @(posedge aclk);
		wr(8'h00, 32'h80, okay);
		repeat (20) @(posedge aclk);
		qv = {vec(s), vec(s)};
		wr(8'h00, 32'hFF, okay);
		take;
		done(s, 0);
		take;
		done(s, 1);
		qv.push_back(vec(2));
		ev(17'h00004);
		take;
		done(2, 0);
		repeat (30) @(posedge aclk);
		qv.push_back(vec(h));
		wr(8'h18, 32'h1 << h, okay);
		take;
		done(h, 1);
		wr(8'h10, 32'h1 << (h - 7), okay);
		qv = {vec(h), vec(s), vec(3), vec(s)};
		ev((17'h00001 << s) | (17'h00001 << h));
		take;
		done(h, 1);
		take;
		done(s, 1);
		ev((17'h00001 << s) | 17'h00008);
		take;
		done(3, 0);
		take;
		done(s, 1);
		gap <= 4'h7;
		qv = {vec(s), vec(h), vec(3)};
		ev(17'h00001 << s);
		take;
		ev(17'h00001 << h);
		take;
		ev(17'h00008);
		done(h, 1);
		repeat (30) @(posedge aclk);
		done(s, 1);
		take;
		done(3, 0);
		repeat (30) @(posedge aclk);
		finish_test;
	end
endmodule // tvi_irq_ctrl_bench
`default_nettype wire

/* tvi_irq_ctrl_monitor.sv */
// Assertion checker for the interrupt logic ports
`timescale 1ns/100ps
`default_nettype none
`include "tvi_regs.svh"
module tvi_irq_ctrl_monitor (
	input wire logic                  aclk,       // Clock
	input wire logic                  aresetn,    // Reset, low
	input wire logic                  awready,    // Write address ready
	input wire logic                  wready,     // Write data ready
	input wire logic                  arready,    // Read address ready
	input wire logic                  bvalid,     // Write response valid
	input wire logic                  rvalid,     // Read data valid
	input wire logic                  instr_done, // Instruction boundary
	input wire logic                  call_ack,   // Vector call start
	input wire logic                  return_from_interrupt_done,  // Return complete
	input wire logic                  irq_req,    // Request
	input wire logic [15:0]           irq_vector, // Vector
	input wire logic                  irq_high,   // High level
	input wire logic [`TVI_IDX_W-1:0] irq_source  // Winner
);
	logic hi_act_q;
	logic lo_act_q;

	// Running levels, rebuilt from the core handshake alone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_act_q <= 1'b0;
			lo_act_q <= 1'b0;
		end else if (call_ack && irq_req) begin
			if (irq_high) hi_act_q <= 1'b1;
			else lo_act_q <= 1'b1;
		end else if (return_from_interrupt_done) begin
			if (hi_act_q) hi_act_q <= 1'b0;
			else lo_act_q <= 1'b0;
		end
	end

	reset_quiet_a: assert property (@(posedge aclk) !aresetn |=> !irq_req && !bvalid && !rvalid)
		else $error("outputs active after reset");
	reset_ready_a: assert property (@(posedge aclk) !aresetn |=> awready && wready && arready)
		else $error("bus not ready after reset");
	ack_drop_a: assert property (@(posedge aclk) disable iff (!aresetn) call_ack && irq_req |=> !irq_req)
		else $error("request stayed after call");
	vec_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_req |-> irq_vector == `TVI_VEC_BASE + (16'(irq_source) << `TVI_VEC_SHIFT))
		else $error("vector does not match source");
	src_range_a: assert property (@(posedge aclk) disable iff (!aresetn) irq_req |-> irq_source < `TVI_SRC_CNT)
		else $error("source out of range");
	high_nopre_a: assert property (@(posedge aclk) disable iff (!aresetn) hi_act_q |-> !irq_req)
		else $error("request during high routine");
	low_only_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
		lo_act_q && !hi_act_q |-> !irq_req || irq_high)
		else $error("low request during low routine");
	return_from_interrupt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		return_from_interrupt_done ##1 !instr_done |=> !irq_req)
		else $error("request before next instruction");
endmodule // tvi_irq_ctrl_monitor

bind tvi_irq_ctrl tvi_irq_ctrl_monitor tvi_irq_ctrl_monitor_i (
	.aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready), .arready(arready),
	.bvalid(bvalid), .rvalid(rvalid), .instr_done(instr_done), .call_ack(call_ack),
	.return_from_interrupt_done(return_from_interrupt_done), .irq_req(irq_req), .irq_vector(irq_vector), .irq_high(irq_high),
	.irq_source(irq_source)
);
`default_nettype wire

/* tvi_pick.sv */
// Fixed-order priority encoder: lowest source position wins
`timescale 1ns/100ps
`default_nettype none
module tvi_pick #(
	parameter int N = 17
) (
	tvi_pick_if.pick p	// Request vector in, winner out
);
	always_comb begin
		p.found = 1'b0;
		p.idx   = 5'h00;
		for (int i = N - 1; i >= 0; i--) begin
			if (p.req[i]) begin
				p.found = 1'b1;
				p.idx   = 5'(i);
			end
		end
	end
endmodule // tvi_pick
`default_nettype wire

/* tvi_pick_if.sv */
// Request vector and winner between the controller and its priority encoder
`timescale 1ns/100ps
`default_nettype none
interface tvi_pick_if #(
	parameter int N = 17
);
	logic [N-1:0] req;
	logic         found;
	logic [4:0]   idx;

	modport ctrl (output req, input found, input idx);
	modport pick (input req, output found, output idx);
endinterface
`default_nettype wire

/* tvi_pkg.sv */
// Types shared by the interrupt logic modules
`include "tvi_regs.svh"
package tvi_pkg;

	typedef enum logic [3:0] {
		TVI_SEL_EN_BASIC,
		TVI_SEL_EN_EXT_A,
		TVI_SEL_EN_EXT_B,
		TVI_SEL_PR_BASIC,
		TVI_SEL_PR_EXT_A,
		TVI_SEL_PR_EXT_B,
		TVI_SEL_PEND_SET,
		TVI_SEL_PEND_CLR,
		TVI_SEL_STATUS,
		TVI_SEL_NONE
	} tvi_sel_type;

	typedef struct packed {
		logic [7:0]                 basic_irq_enable_reg;
		logic [7:0]                 extended_irq_enable_reg_a;
		logic [7:0]                 extended_irq_enable_reg_b;
		logic [7:0]                 basic_priority_reg;
		logic [7:0]                 extended_priority_reg_a;
		logic [7:0]                 extended_priority_reg_b;
		logic [`TVI_SRC_CNT-1:0]    pend;
		logic [1:0]                 active;
		logic                       hold;
		logic                       req;
		logic                       high;
		logic [15:0]                vec;
		logic [`TVI_IDX_W-1:0]      idx;
		logic                       aw_have;
		logic [`TVI_ADDR_W-1:0]     aw_addr;
		logic                       w_have;
		logic [31:0]                w_data;
		logic [3:0]                 w_strb;
		logic                       awready;
		logic                       wready;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
	} tvi_state_type;

endpackage

/* tvi_regs.svh */
// Offsets, field positions and reset values of the two-level vectored interrupt logic
`ifndef TVI_REGS_SVH
`define TVI_REGS_SVH

`define TVI_SRC_CNT         17
`define TVI_IDX_W           5
`define TVI_ADDR_W          8
`define TVI_GLOBAL_EN_BIT   7
`define TVI_BASIC_SRC_CNT   7
`define TVI_EXT_A_SRC_CNT   8
`define TVI_EXT_B_SRC_CNT   2

`define TVI_OFF_EN_BASIC    8'h00
`define TVI_OFF_EN_EXT_A    8'h04
`define TVI_OFF_EN_EXT_B    8'h08
`define TVI_OFF_PR_BASIC    8'h0C
`define TVI_OFF_PR_EXT_A    8'h10
`define TVI_OFF_PR_EXT_B    8'h14
`define TVI_OFF_PEND_SET    8'h18
`define TVI_OFF_PEND_CLR    8'h1C
`define TVI_OFF_STATUS      8'h20

`define TVI_VEC_BASE        16'h0003
`define TVI_VEC_SHIFT       3
`define TVI_HW_CLR_MASK     17'h0000F
`define TVI_REG8_RESET      8'h00

`define TVI_RESP_OKAY       2'h0
`define TVI_RESP_SLVERR     2'h2

`endif
